// ===== src/asq_top.sv
// Serial command sequencer of a delta-sigma converter, peripheral side.
// Assumes the host drives sclk_i only while cs_n_i is low, in mode 1.
// Contract
// - Clock idles low; bits change on rising, sampled on falling edges.
// - Chip select high returns the serial interface to its start state.
// - Reset command 06h reinitialises; host waits 4096 clocks afterwards.
// - Status ready bit reads 0 when configuration may proceed.
// - Writing 00h to status clears the power-on flag.
// - Register write loads configuration; register read returns contents.
// - Start command 08h begins continuous conversion.
// - Ready pin falls each time a new result is available; here a result is taken only once the previous one has been read.
// - After read-data command, 16 clocks shift the result out.
// - Stop command 0Ah halts conversion into standby.
// - Amplifier enable field 10 bypasses the amplifier, forcing gain one.
// - With start pin low, only commands govern conversions.
`timescale 1ns/1ps
module asq_top
   import asq_pkg::*;
(
   // System clock and reset
   input  wire logic                clock_i,
   input  wire logic                sys_rst_i,
   // Serial link
   input  wire logic                sclk_i,
   input  wire logic                cs_n_i,
   input  wire logic                din_i,
   output logic                     dout_o,
   output logic                     dout_oe_n_o,
   // Conversion core
   input  wire logic                conv_start_i,
   input  wire logic [RESULT_W-1:0] result_i,
   input  wire logic                result_valid_i,
   // Status and configuration
   output logic                     conversion_ready_n_o,
   output logic                     converting_o,
   output logic                     amp_bypass_o,
   output logic [2:0]               gain_code_o
);

   // ****************************************
   // Declarations
   // ****************************************
   asq_link_t l_q, l_d;
   asq_cfg_t  c_q, c_d;
   asq_sys_t  s_q, s_d;
   asq_ev_t   ev;
   asq_ev_t   tog_s;
   asq_ev_t   ev_edge;
   asq_wr_t   wr;
   logic      link_rst;
   logic      dout_q;
   logic      busy_l;
   logic      rdy_n_l;
   logic      start_pin_s;
   logic      conv_w;
   logic [7:0] byte_v;
   logic [4:0] addr_n;
   logic       shifting;

   localparam asq_sys_t SYS_RST = '{run: 1'b0, busy: 1'b1, wait_cnt: RESET_WAIT_LAST,
                                    ready_n: 1'b1, data: '0, tog_prev: '0};

   // Register read with live status bits
   function automatic logic [7:0] rd_reg(input logic [4:0] a, input asq_cfg_t c, input logic busy);
      logic [7:0] v;
      v = 8'h00;
      if (a == REG_STATUS) begin
         v[POR_BIT]     = c.por;
         v[READY_N_BIT] = busy;
      end else if (32'(a) < NUM_REGS) begin
         v = c.regs[a];
      end
      return v;
   endfunction

   // ****************************************
   // Link domain
   // ****************************************
   // select high resets link
   assign link_rst = sys_rst_i | cs_n_i;
   assign byte_v   = {l_q.sh, din_i};
   assign addr_n   = l_q.addr + 5'h01;
   assign shifting = (l_q.ph == PH_OUT) || (l_q.ph == PH_RDAT);

   // Status levels carried into the link clock
   asq_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_link (
      .clk_i (sclk_i),
      .rst_i (sys_rst_i),
      .d_i   ({s_q.busy, s_q.ready_n}),
      .q_o   ({busy_l, rdy_n_l})
   );

   // Command decode on falling edges
   always_comb begin
      l_d         = l_q;
      ev          = '0;
      wr          = '0;
      l_d.sh      = byte_v[6:0];
      l_d.bit_cnt = l_q.bit_cnt + 3'h1;
      if (shifting) begin
         l_d.tx = {l_q.tx[RESULT_W-2:0], 1'b0};
      end
      if (l_q.bit_cnt == 3'h7) begin
         unique case (l_q.ph)
            PH_CMD: begin
               if (byte_v == CMD_RESET) begin
                  ev.reset = 1'b1;
               end else if (byte_v == CMD_START) begin
                  ev.start = 1'b1;
               end else if (byte_v == CMD_STOP) begin
                  ev.stop = 1'b1;
               end else if (byte_v == CMD_RDATA) begin
                  ev.rdata = 1'b1;
                  l_d.tx   = s_q.data;
                  l_d.cnt  = RESULT_BYTES_M1;
                  l_d.ph   = PH_OUT;
               end else if (byte_v[7:5] == OP_REGISTER_READ_CMD) begin
                  l_d.addr = byte_v[4:0];
                  l_d.ph   = PH_RCNT;
               end else if (byte_v[7:5] == OP_REGISTER_WRITE_CMD) begin
                  l_d.addr = byte_v[4:0];
                  l_d.ph   = PH_WCNT;
               end
            end
            PH_RCNT: begin
               l_d.cnt = byte_v[4:0];
               l_d.tx  = {rd_reg(l_q.addr, c_q, busy_l), 8'h00};
               l_d.ph  = PH_RDAT;
            end
            PH_WCNT: begin
               l_d.cnt = byte_v[4:0];
               l_d.ph  = PH_WDAT;
            end
            PH_WDAT: begin
               wr = '{en: 1'b1, addr: l_q.addr, data: byte_v};
               if (l_q.cnt == 5'h00) begin
                  l_d.ph = PH_CMD;
               end else begin
                  l_d.cnt  = l_q.cnt - 5'h01;
                  l_d.addr = addr_n;
               end
            end
            PH_RDAT: begin
               if (l_q.cnt == 5'h00) begin
                  l_d.ph = PH_CMD;
               end else begin
                  l_d.cnt  = l_q.cnt - 5'h01;
                  l_d.addr = addr_n;
                  l_d.tx   = {rd_reg(addr_n, c_q, busy_l), 8'h00};
               end
            end
            PH_OUT: begin
               if (l_q.cnt == 5'h00) begin
                  l_d.ph = PH_CMD;
               end else begin
                  l_d.cnt = l_q.cnt - 5'h01;
               end
            end
            default: begin
               l_d.ph = PH_CMD;
            end
         endcase
      end
   end

   // Link state, cleared whenever select is high
   always_ff @(negedge sclk_i or posedge link_rst) begin
      if (link_rst) begin
         l_q <= '{ph: PH_CMD, bit_cnt: 3'h0, sh: 7'h00, addr: 5'h00, cnt: 5'h00, tx: '0};
      end else begin
         l_q <= l_d;
      end
   end

   // Register file and event toggles
   always_comb begin
      c_d     = c_q;
      c_d.tog = c_q.tog ^ ev;
      if (ev.reset) begin
         c_d.regs = '0;
         c_d.por  = 1'b1;
      end else if (wr.en) begin
         if (wr.addr == REG_STATUS) begin
            c_d.por = c_q.por & wr.data[POR_BIT];
         end else if (32'(wr.addr) < NUM_REGS) begin
            c_d.regs[wr.addr] = wr.data;
         end
      end
   end

   // Configuration survives deselect
   always_ff @(negedge sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         c_q <= '{por: 1'b1, tog: '0, regs: {NUM_REGS{REG_RST}}};
      end else begin
         c_q <= c_d;
      end
   end

   always_ff @(posedge sclk_i or posedge link_rst) begin
      if (link_rst) begin
         dout_q <= 1'b1;
      end else begin
         dout_q <= shifting ? l_q.tx[RESULT_W-1] : rdy_n_l;
      end
   end

   assign dout_o      = dout_q;
   assign dout_oe_n_o = cs_n_i;  // Drive only while selected

   assign amp_bypass_o = c_q.regs[REG_GAIN][AMP_EN_HI:AMP_EN_LO] == AMP_BYPASS;
   assign gain_code_o  = amp_bypass_o ? GAIN_ONE : c_q.regs[REG_GAIN][GAIN_HI:0];

   // ****************************************
   // System domain
   // ****************************************
   // Command toggles into the system clock
   asq_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_sync_ev (
      .clk_i (clock_i),
      .rst_i (sys_rst_i),
      .d_i   (c_q.tog),
      .q_o   (tog_s)
   );

   // Conversion start pin
   asq_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_pin (
      .clk_i (clock_i),
      .rst_i (sys_rst_i),
      .d_i   (conv_start_i),
      .q_o   (start_pin_s)
   );

   assign ev_edge = tog_s ^ s_q.tog_prev;
   assign conv_w  = (s_q.run | start_pin_s) & ~s_q.busy;

   // Run control, reset wait and result hand-off
   always_comb begin
      s_d          = s_q;
      s_d.tog_prev = tog_s;
      if (s_q.busy) begin
         if (s_q.wait_cnt == 12'h000) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.wait_cnt = s_q.wait_cnt - 12'h001;
         end
      end
      if (ev_edge.start) begin
         s_d.run = 1'b1;
      end
      if (ev_edge.stop) begin
         s_d.run = 1'b0;
      end
      if (ev_edge.rdata) begin
         s_d.ready_n = 1'b1;
      end
      if (result_valid_i && conv_w && (s_q.ready_n || ev_edge.rdata)) begin
         s_d.data    = result_i;
         s_d.ready_n = 1'b0;
      end
      if (ev_edge.reset) begin
         s_d.run      = 1'b0;
         s_d.busy     = 1'b1;
         s_d.wait_cnt = RESET_WAIT_LAST;
         s_d.ready_n  = 1'b1;
      end
   end

   // System state
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= SYS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign conversion_ready_n_o = s_q.ready_n;
   assign converting_o         = conv_w;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_out_byte;
      (l_q.ph == PH_OUT)[*8];
   endsequence

   // Last byte: the sixteenth bit is the final one before command phase
   sequence s_out_tail;
      (l_q.ph == PH_OUT)[*7] ##1
      (l_q.ph == PH_OUT && l_q.cnt == 5'h00 && l_q.bit_cnt == 3'h7 && l_d.ph == PH_CMD);
   endsequence

   property p_rdata_len;
      @(negedge sclk_i) disable iff (link_rst)
      (ev.rdata) |=> s_out_byte ##1 s_out_tail;
   endproperty
   a_rdata_len: assert property (p_rdata_len) else $error("result frame not 16 bits");

   property p_reset_wait;
      @(posedge clock_i) disable iff (sys_rst_i)
      ev_edge.reset |=> s_q.busy && (s_q.wait_cnt == RESET_WAIT_LAST) && !s_q.run;
   endproperty
   a_reset_wait: assert property (p_reset_wait) else $error("reset wait not started");

   property p_busy_end;
      @(posedge clock_i) disable iff (sys_rst_i)
      $fell(s_q.busy) |-> ($past(s_q.wait_cnt) == 12'h000);
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy ended early");

   property p_ready_bit;
      @(negedge sclk_i) disable iff (link_rst)
      (l_q.ph == PH_RCNT && l_q.bit_cnt == 3'h7 && l_q.addr == REG_STATUS)
         |=> (l_q.tx[8 + READY_N_BIT] == $past(busy_l));
   endproperty
   a_ready_bit: assert property (p_ready_bit) else $error("status ready bit wrong");

   // Checked at the first edge of the next frame; the flag survives deselect
   property p_por_clear;
      @(negedge sclk_i) disable iff (sys_rst_i)
      (wr.en && wr.addr == REG_STATUS && wr.data == 8'h00 && !ev.reset) |=> !c_q.por;
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("power-on flag kept");

   property p_reg_write;
      @(negedge sclk_i) disable iff (sys_rst_i)
      (wr.en && wr.addr == REG_GAIN) |=> (c_q.regs[REG_GAIN] == $past(wr.data));
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("register write lost");

   property p_start_run;
      @(posedge clock_i) disable iff (sys_rst_i)
      (ev_edge.start && !ev_edge.stop && !ev_edge.reset) |=> s_q.run;
   endproperty
   a_start_run: assert property (p_start_run) else $error("start ignored");

   property p_stop_run;
      @(posedge clock_i) disable iff (sys_rst_i)
      ev_edge.stop |=> !s_q.run;
   endproperty
   a_stop_run: assert property (p_stop_run) else $error("stop ignored");

   property p_ready_fall;
      @(posedge clock_i) disable iff (sys_rst_i)
      (result_valid_i && conv_w && s_q.ready_n && !ev_edge.reset)
         |=> !conversion_ready_n_o && (s_q.data == $past(result_i));
   endproperty
   a_ready_fall: assert property (p_ready_fall) else $error("ready did not fall");

   property p_bypass;
      @(posedge clock_i) disable iff (sys_rst_i)
      amp_bypass_o |-> (gain_code_o == GAIN_ONE);
   endproperty
   a_bypass: assert property (p_bypass) else $error("gain above one in bypass");

   property p_pin_low;
      @(posedge clock_i) disable iff (sys_rst_i)
      (!start_pin_s && !s_q.run) |-> !converting_o;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("converting without command");

endmodule // asq_top

// ===== src/asq_pkg.sv
// Shared constants and types for the conversion sequencer.
// Assumes one system clock of 200 MHz and a serial link clock from the host.
package asq_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int       NUM_REGS    = 18;
   localparam logic [4:0] REG_STATUS = 5'h01;
   localparam logic [4:0] REG_GAIN   = 5'h03;
   localparam logic [7:0] REG_RST    = 8'h00;
   localparam int       POR_BIT     = 7;
   localparam int       READY_N_BIT = 6;
   localparam int       AMP_EN_HI   = 6;
   localparam int       AMP_EN_LO   = 5;
   localparam int       GAIN_HI     = 2;
   localparam logic [1:0] AMP_BYPASS = 2'h2;
   localparam logic [2:0] GAIN_ONE   = 3'h0;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_RESET = 8'h06;
   localparam logic [7:0] CMD_START = 8'h08;
   localparam logic [7:0] CMD_STOP  = 8'h0A;
   localparam logic [7:0] CMD_RDATA = 8'h12;
   localparam logic [2:0] OP_REGISTER_READ_CMD   = 3'h1;
   localparam logic [2:0] OP_REGISTER_WRITE_CMD   = 3'h2;

   // ****************************************
   // Timing and widths
   // ****************************************
   localparam int         CLK_MHZ         = 200;
   localparam int         RESET_WAIT_CLKS = 4096;
   localparam logic [11:0] RESET_WAIT_LAST = 12'(RESET_WAIT_CLKS - 1);
   localparam int         RESULT_W        = 16;
   localparam logic [4:0] RESULT_BYTES_M1 = 5'h01;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      PH_CMD  = 3'b000,
      PH_RCNT = 3'b001,
      PH_RDAT = 3'b010,
      PH_WCNT = 3'b011,
      PH_WDAT = 3'b100,
      PH_OUT  = 3'b101
   } asq_phase_t;

   typedef struct packed {
      logic reset;
      logic start;
      logic stop;
      logic rdata;
   } asq_ev_t;

   typedef struct packed {
      logic       en;
      logic [4:0] addr;
      logic [7:0] data;
   } asq_wr_t;

   typedef struct packed {
      asq_phase_t          ph;
      logic [2:0]          bit_cnt;
      logic [6:0]          sh;
      logic [4:0]          addr;
      logic [4:0]          cnt;
      logic [RESULT_W-1:0] tx;
   } asq_link_t;

   typedef struct packed {
      logic                        por;
      asq_ev_t                     tog;
      logic [NUM_REGS-1:0][7:0]    regs;
   } asq_cfg_t;

   typedef struct packed {
      logic                run;
      logic                busy;
      logic [11:0]         wait_cnt;
      logic                ready_n;
      logic [RESULT_W-1:0] data;
      asq_ev_t             tog_prev;
   } asq_sys_t;

endpackage

// ===== src/asq_sync.sv
// Three-stage level synchroniser, one per bit.
// Assumes an asynchronous, active-high reset in the receiving domain.
`timescale 1ns/1ps
module asq_sync
   import asq_pkg::*;
#(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Receiving clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Level in and filtered level out
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } asq_sync_st_t;

   asq_sync_st_t st_q, st_d;

   // Shift chain; output follows once stages two and three agree
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.q  = ((st_q.s2 ~^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.q);
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o = st_q.q;

endmodule // asq_sync

// ===== verification/asq_host.sv
// Host model: serial controller driving the sequencer's link in mode 1.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module asq_host #(
   parameter int PWRUP_NS = 500  // Shortened power-up wait
) (
   // Link pins toward the device
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   // Serial out / ready wire from the device
   input  wire logic dout_i
);
   // ****************************************
   // Frame tasks
   // ****************************************
   // clock idles low, deselected
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end

   task automatic pwrup();
      #(PWRUP_NS);
   endtask

   task automatic sel();
      cs_n_o = 1'b0;
      #40;
   endtask

   // launch on rise, sample on fall
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sclk_o = 1'b1;
         din_o  = tx[i];
         #32;
         sclk_o = 1'b0;
         rx[i]  = dout_i;
         #32;
      end
   endtask

   // hold select after last edge, then release
   task automatic desel();
      #40;
      cs_n_o = 1'b1;
      din_o  = ~din_o;  // Released line no longer shows last bit
      #100;
   endtask
endmodule // asq_host

// ===== verification/test_asq_top.sv
// Self-checking bench for the conversion sequencer.
// Assumes the host model drives the link and the bench plays the conversion core.
`timescale 1ns/1ps
module test_asq_top
   import asq_pkg::*;
;
   logic                clock_i;
   logic                sys_rst_i;
   logic                sclk;
   logic                cs_n;
   logic                din;
   logic                dout_o;
   logic                dout_oe_n_o;
   logic                dout_w;
   logic                conv_start_i;
   logic [RESULT_W-1:0] result_i;
   logic                result_valid_i;
   logic                conversion_ready_n_o;
   logic                converting_o;
   logic                amp_bypass_o;
   logic [2:0]          gain_code_o;
   int                  err_total;
   int                  check_count;
   int                  cyc;
   logic [7:0]          q0;
   logic [7:0]          q1;

   // ****************************************
   // Clock, parts and wiring
   // ****************************************
   initial clock_i = 1'b0;
   always #2.5 clock_i = ~clock_i;

   // Pulled-up ready wire when not driven
   assign dout_w = dout_oe_n_o ? 1'b1 : dout_o;

   asq_top uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
      .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .conv_start_i(conv_start_i), .result_i(result_i),
      .result_valid_i(result_valid_i), .conversion_ready_n_o(conversion_ready_n_o),
      .converting_o(converting_o), .amp_bypass_o(amp_bypass_o), .gain_code_o(gain_code_o));

   asq_host host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_w));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic close_out();
      $display("Counts: %0d checks, %0d mismatches", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic cmd(input logic [7:0] op);
      logic [7:0] r;
      host.sel();
      host.xfer(op, 8, r);
      host.desel();
   endtask

   task automatic reg_wr(input logic [4:0] a, input int n, input logic [7:0] d0, input logic [7:0] d1);
      logic [7:0] r;
      host.sel();
      host.xfer({OP_REGISTER_WRITE_CMD, a}, 8, r);
      host.xfer(8'(n - 1), 8, r);
      host.xfer(d0, 8, r);
      if (n > 1) host.xfer(d1, 8, r);
      host.desel();
   endtask

   task automatic reg_rd(input logic [4:0] a, input int n, output logic [7:0] r0, output logic [7:0] r1);
      logic [7:0] r;
      host.sel();
      host.xfer({OP_REGISTER_READ_CMD, a}, 8, r);
      host.xfer(8'(n - 1), 8, r);
      host.xfer(8'h00, 8, r0);
      r1 = 8'h00;
      if (n > 1) host.xfer(8'h00, 8, r1);
      host.desel();
   endtask

   // Core delivers one result pulse
   task automatic post(input logic [15:0] v);
      @(posedge clock_i);
      result_i       <= v;
      result_valid_i <= 1'b1;
      @(posedge clock_i);
      result_valid_i <= 1'b0;
   endtask

   // ****************************************
   // Run limit
   // ****************************************
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         close_out();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      err_total = 0;
      check_count = 0;
      cyc = 0;
      sys_rst_i = 1'b1;
      conv_start_i = 1'b0;
      result_i = 16'h0000;
      result_valid_i = 1'b0;
      wait_clk(16);
      chk_bit("ready_n in reset", 1'b1, conversion_ready_n_o);
      chk_bit("converting in reset", 1'b0, converting_o);
      @(posedge clock_i);
      sys_rst_i <= 1'b0;
      host.pwrup();
      chk_bit("oe idle", 1'b1, dout_oe_n_o);
      reg_rd(REG_STATUS, 1, q0, q1);
      chk_val("status busy", 16'h00C0, {8'h00, q0});
      wait_clk(RESET_WAIT_CLKS);
      reg_rd(REG_STATUS, 1, q0, q1);
      chk_val("status ready", 16'h0080, {8'h00, q0});
      reg_wr(REG_STATUS, 1, 8'h00, 8'h00);
      reg_rd(REG_STATUS, 1, q0, q1);
      chk_val("flag cleared", 16'h0000, {8'h00, q0});
      $display("Test power-up done");

      reg_wr(5'h10, 1, 8'h00, 8'h00);
      reg_wr(5'h02, 2, 8'h5A, 8'h40);
      chk_bit("bypass set", 1'b1, amp_bypass_o);
      chk_val("gain in bypass", 16'h0000, {13'h0000, gain_code_o});
      reg_rd(5'h02, 2, q0, q1);
      chk_val("readback pair", 16'h5A40, {q0, q1});
      reg_wr(REG_GAIN, 1, 8'h03, 8'h00);
      chk_bit("bypass clear", 1'b0, amp_bypass_o);
      chk_val("gain code", 16'h0003, {13'h0000, gain_code_o});
      reg_wr(5'h14, 1, 8'hFF, 8'h00);
      reg_rd(5'h14, 1, q0, q1);
      chk_val("unmapped", 16'h0000, {8'h00, q0});
      host.sel();
      chk_bit("oe selected", 1'b0, dout_oe_n_o);
      host.xfer(8'hFF, 4, q1);
      host.desel();
      reg_rd(REG_GAIN, 1, q0, q1);
      chk_val("after abort", 16'h0003, {8'h00, q0});
      $display("Test registers done");

      post(16'h7777);
      wait_clk(2);
      chk_bit("idle result ignored", 1'b1, conversion_ready_n_o);
      cmd(CMD_START);
      wait_clk(10);
      chk_bit("running", 1'b1, converting_o);
      post(16'hA5C3);
      wait_clk(1);
      chk_bit("ready low", 1'b0, conversion_ready_n_o);
      post(16'h1234);
      host.sel();
      host.xfer(CMD_RDATA, 8, q0);
      host.xfer(8'h00, 8, q0);
      host.xfer(8'h00, 8, q1);
      host.desel();
      chk_val("result", 16'hA5C3, {q0, q1});
      wait_clk(10);
      chk_bit("ready released", 1'b1, conversion_ready_n_o);
      $display("Test conversion done");

      cmd(CMD_STOP);
      wait_clk(10);
      chk_bit("stopped", 1'b0, converting_o);
      @(posedge clock_i);
      conv_start_i <= 1'b1;
      wait_clk(10);
      chk_bit("pin converts", 1'b1, converting_o);
      @(posedge clock_i);
      conv_start_i <= 1'b0;
      wait_clk(10);
      chk_bit("pin low standby", 1'b0, converting_o);
      $display("Test stop and pin done");

      cmd(CMD_RESET);
      wait_clk(10);
      chk_val("gain cleared", 16'h0000, {13'h0000, gain_code_o});
      reg_rd(REG_STATUS, 1, q0, q1);
      chk_val("status after cmd", 16'h00C0, {8'h00, q0});
      wait_clk(RESET_WAIT_CLKS);
      reg_rd(REG_STATUS, 1, q0, q1);
      chk_val("ready after cmd", 16'h0080, {8'h00, q0});
      $display("Test reset command done");
      close_out();
   end
endmodule // test_asq_top
